// *** lpnp_pkg.sv ***
package lpnp_pkg;

  // Byte-wide register map of the switch's indirect access path
  localparam logic [7:0]  LPNP_ADDR_SEL       = 8'h6E;
  localparam logic [7:0]  LPNP_ADDR_OFS       = 8'h6F;
  localparam logic [7:0]  LPNP_ADDR_DATA      = 8'hA0;

  // Indirect select fields
  localparam int          LPNP_SEL_FUNC_MSB   = 7;
  localparam int          LPNP_SEL_FUNC_LSB   = 5;
  localparam int          LPNP_SEL_PORT_MSB   = 3;
  localparam int          LPNP_SEL_PORT_LSB   = 0;
  localparam logic [2:0]  LPNP_FUNC_EEE       = 3'h1;

  // Indirect offsets of the two halves
  localparam logic [7:0]  LPNP_OFS_HI         = 8'h10;
  localparam logic [7:0]  LPNP_OFS_LO         = 8'h11;

  // Codeword field positions
  localparam int          LPNP_BIT_NEXT_PAGE  = 15;
  localparam int          LPNP_BIT_ACK        = 14;
  localparam int          LPNP_BIT_MSG_PAGE   = 13;
  localparam int          LPNP_BIT_ACK2       = 12;
  localparam int          LPNP_BIT_TOGGLE     = 11;
  localparam int          LPNP_CODE_MSB       = 10;

  // Consistency compare ignores the acknowledge bit
  localparam logic [15:0] LPNP_MATCH_MASK     = 16'hBFFF;
  localparam logic [1:0]  LPNP_CONSISTENT_CNT = 2'h3;

  // Values after reset
  localparam logic [15:0] LPNP_REG_RESET      = 16'h0000;
  localparam logic [7:0]  LPNP_SEL_RESET      = 8'h00;
  localparam logic [7:0]  LPNP_OFS_RESET      = 8'h00;
  localparam logic [7:0]  LPNP_BYTE_RESET     = 8'h00;

endpackage : lpnp_pkg

// *** lpnp_rx_reg.sv ***
`timescale 1ns/1ps
// Behaviour
// R1: Bit 15 shows partner next-page flag; one means more pages follow.
// R2: Bit 14 shows partner acknowledge flag, codeword received by the sender.
// R3: Acknowledge is always codeword bit D14, whatever the selector or encoding.
// R4: Acknowledge only after three consecutive consistent bursts, ignoring acknowledge bit.
// R5: Bit 13 shows message-page flag; one message page, zero unformatted.
// R6: Toggle bit 11 is always inverse of previously exchanged codeword toggle.
// R7: First next page toggle equals inverse of base codeword bit 11.
// R8: Bits 10 to 0 hold partner message or unformatted code field.
// R9: Bit 12 shows acknowledge-2 flag; one means sender can comply.
// R10: Software selects function 001 and port, writes offset, reads data byte.
// R11: Indirect offset 0x10 reads upper byte, 0x11 reads lower byte.
// R12: Fields are read-only, hold last received next page, zero after reset.
module lpnp_rx_reg
  import lpnp_pkg::*;
#(
  parameter logic [3:0] PORT_ID   = 4'h1,
  parameter int         NUM_PORTS = 4
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cw_valid,
  input  wire logic [15:0] cw_word,
  input  wire logic        cw_is_next,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             np_ack_ready,
  output logic             np_page_taken,
  output logic             np_toggle_err
);

  generate
    if (PORT_ID < 4'h1 || int'(PORT_ID) > NUM_PORTS) begin : g_bad_port
      $error("PORT_ID outside the served port range");
    end
  endgenerate

  logic [15:0] lp_np_r;
  logic [15:0] last_word_r;
  logic [1:0]  match_cnt_r;
  logic        prev_toggle_r;
  logic [7:0]  sel_r;
  logic [7:0]  ofs_r;
  logic [7:0]  rdata_r;
  logic        consistent;
  logic        take;
  logic        toggle_ok;
  logic        latch_np;
  logic        sel_hit;
  logic [7:0]  data_byte;

  // Burst matches the previous one apart from the acknowledge bit
  assign consistent = cw_valid && (match_cnt_r != 2'h0) &&
                      ((cw_word & LPNP_MATCH_MASK) == (last_word_r & LPNP_MATCH_MASK)); // R4
  assign take       = consistent && (match_cnt_r == (LPNP_CONSISTENT_CNT - 2'h1));      // R4
  assign toggle_ok  = cw_word[LPNP_BIT_TOGGLE] != prev_toggle_r;                        // R6
  assign latch_np   = take && cw_is_next && toggle_ok;

  assign np_ack_ready  = (match_cnt_r == LPNP_CONSISTENT_CNT); // R4
  assign np_page_taken = latch_np;
  assign np_toggle_err = take && cw_is_next && !toggle_ok;      // R6

  // Consecutive consistent burst counter, saturating at three
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match_cnt_r <= 2'h0;
      last_word_r <= LPNP_REG_RESET;
    end else if (cw_valid) begin
      last_word_r <= cw_word;
      if (!consistent) begin
        match_cnt_r <= 2'h1; // R4
      end else if (match_cnt_r != LPNP_CONSISTENT_CNT) begin
        match_cnt_r <= match_cnt_r + 2'h1; // R4
      end
    end
  end

  // Toggle of the last exchanged codeword, seeded by the base page
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_toggle_r <= 1'b0;
    end else if (take && (!cw_is_next || toggle_ok)) begin
      prev_toggle_r <= cw_word[LPNP_BIT_TOGGLE]; // R7
    end
  end

  // Partner next page holding register, fields kept at codeword positions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_np_r <= LPNP_REG_RESET; // R12
    end else if (latch_np) begin
      lp_np_r <= cw_word; // R1 R2 R3 R5 R8 R9
    end
  end

  // Indirect select and offset registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= LPNP_SEL_RESET;
      ofs_r <= LPNP_OFS_RESET;
    end else if (reg_wr) begin
      if (reg_addr == LPNP_ADDR_SEL) begin
        sel_r <= reg_wdata; // R10
      end
      if (reg_addr == LPNP_ADDR_OFS) begin
        ofs_r <= reg_wdata; // R10
      end
    end
  end

  assign sel_hit = (sel_r[LPNP_SEL_FUNC_MSB:LPNP_SEL_FUNC_LSB] == LPNP_FUNC_EEE) &&
                   (sel_r[LPNP_SEL_PORT_MSB:LPNP_SEL_PORT_LSB] == PORT_ID);

  always_comb begin
    data_byte = LPNP_BYTE_RESET;
    if (sel_hit) begin
      case (ofs_r)
        LPNP_OFS_HI: data_byte = lp_np_r[15:8]; // R11
        LPNP_OFS_LO: data_byte = lp_np_r[7:0];  // R11
        default:     data_byte = LPNP_BYTE_RESET;
      endcase
    end
  end

  // Read data registered; writes to the data byte are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= LPNP_BYTE_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        LPNP_ADDR_SEL:  rdata_r <= sel_r;
        LPNP_ADDR_OFS:  rdata_r <= ofs_r;
        LPNP_ADDR_DATA: rdata_r <= data_byte; // R12
        default:        rdata_r <= LPNP_BYTE_RESET;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Burst back to back with the previous one and equal apart from the acknowledge bit
  sequence s_same_burst;
    cw_valid && $past(cw_valid) && ((cw_word & LPNP_MATCH_MASK) == ($past(cw_word) & LPNP_MATCH_MASK));
  endsequence

  sequence s_three_bursts;
    cw_valid ##1 s_same_burst ##1 s_same_burst;
  endsequence

  sequence s_read_data(logic [7:0] ofs);
    sel_hit && ofs_r == ofs && reg_rd && reg_addr == LPNP_ADDR_DATA;
  endsequence

  property p_next_page_bit;
    latch_np |=> lp_np_r[LPNP_BIT_NEXT_PAGE] == $past(cw_word[LPNP_BIT_NEXT_PAGE]);
  endproperty
  a_next_page_bit: assert property (p_next_page_bit) else $error("next page flag not captured"); // R1

  property p_ack_bit;
    latch_np |=> lp_np_r[LPNP_BIT_ACK] == $past(cw_word[14]);
  endproperty
  a_ack_bit: assert property (p_ack_bit) else $error("acknowledge not taken from D14"); // R2 R3

  property p_msg_page_bit;
    latch_np |=> lp_np_r[LPNP_BIT_MSG_PAGE] == $past(cw_word[LPNP_BIT_MSG_PAGE]);
  endproperty
  a_msg_page_bit: assert property (p_msg_page_bit) else $error("message page flag not captured"); // R5

  property p_ack2_bit;
    latch_np |=> lp_np_r[LPNP_BIT_ACK2] == $past(cw_word[LPNP_BIT_ACK2]);
  endproperty
  a_ack2_bit: assert property (p_ack2_bit) else $error("acknowledge 2 flag not captured"); // R9

  property p_code_field;
    latch_np |=> lp_np_r[LPNP_CODE_MSB:0] == $past(cw_word[LPNP_CODE_MSB:0]);
  endproperty
  a_code_field: assert property (p_code_field) else $error("code field not captured"); // R8

  property p_ack_after_three;
    s_three_bursts |=> np_ack_ready;
  endproperty
  a_ack_after_three: assert property (p_ack_after_three) else $error("ack not ready after three bursts"); // R4

  property p_no_early_ack;
    $rose(np_ack_ready) |-> $past(consistent) && $past(match_cnt_r) == 2'h2;
  endproperty
  a_no_early_ack: assert property (p_no_early_ack) else $error("ack ready too early"); // R4

  property p_toggle_inverts;
    latch_np |=> lp_np_r[LPNP_BIT_TOGGLE] != $past(prev_toggle_r) && prev_toggle_r == lp_np_r[LPNP_BIT_TOGGLE];
  endproperty
  a_toggle_inverts: assert property (p_toggle_inverts) else $error("toggle not inverse of previous"); // R6

  property p_base_seeds_toggle;
    take && !cw_is_next |=> prev_toggle_r == $past(cw_word[LPNP_BIT_TOGGLE]);
  endproperty
  a_base_seeds_toggle: assert property (p_base_seeds_toggle) else $error("base page did not seed toggle"); // R7

  property p_read_hi;
    s_read_data(LPNP_OFS_HI) |=> reg_rdata == $past(lp_np_r[15:8]);
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("upper byte read wrong"); // R11

  property p_read_lo;
    s_read_data(LPNP_OFS_LO) |=> reg_rdata == $past(lp_np_r[7:0]);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("lower byte read wrong"); // R11

  property p_read_only;
    !latch_np |=> $stable(lp_np_r);
  endproperty
  a_read_only: assert property (p_read_only) else $error("register changed without a next page"); // R12

  property p_toggle_err_drops;
    np_toggle_err |=> $stable(lp_np_r) && $stable(prev_toggle_r);
  endproperty
  a_toggle_err_drops: assert property (p_toggle_err_drops) else $error("page with wrong toggle was latched"); // R6

  property p_no_relatch;
    np_ack_ready && cw_valid |-> !np_page_taken;
  endproperty
  a_no_relatch: assert property (p_no_relatch) else $error("repeated page latched again"); // R4

endmodule : lpnp_rx_reg

// *** lpnp_partner.sv ***
`timescale 1ns/1ps
module lpnp_partner (
  input  wire logic        clk,
  output logic             cw_valid,
  output logic [15:0]      cw_word,
  output logic             cw_is_next
);
  initial begin
    cw_valid   = 1'b0;
    cw_word    = 16'h0000;
    cw_is_next = 1'b0;
  end
  // Repeats one codeword n times, then drops valid and scrambles the word
  task automatic send(input logic [15:0] w, input logic nx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cw_valid   <= 1'b1;
      cw_word    <= w;
      cw_is_next <= nx;
    end
    @(posedge clk);
    cw_valid <= 1'b0;
    cw_word  <= ~w;
  endtask : send
endmodule : lpnp_partner

// *** tb.sv ***
`timescale 1ns/1ps
module tb
  import lpnp_pkg::*;
;
  logic        clk, arst_n, reg_wr, reg_rd, cw_valid, cw_is_next;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] cw_word;
  logic        np_ack_ready, np_page_taken, np_toggle_err, err_seen;
  logic [7:0]  n_taken;
  int          n_mismatch, total_checks;

  lpnp_partner P (.clk(clk), .cw_valid(cw_valid), .cw_word(cw_word), .cw_is_next(cw_is_next));
  lpnp_rx_reg DUT (.clk(clk), .arst_n(arst_n), .cw_valid(cw_valid), .cw_word(cw_word),
    .cw_is_next(cw_is_next), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .np_ack_ready(np_ack_ready),
    .np_page_taken(np_page_taken), .np_toggle_err(np_toggle_err));

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_seen <= 1'b0;
      n_taken  <= 8'h00;
    end else begin
      if (np_toggle_err === 1'b1) err_seen <= 1'b1;
      if (np_page_taken === 1'b1) n_taken <= n_taken + 8'h01;
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 check("rdata", reg_rdata, exp);
  endtask : rd
  // Reads both halves of the partner page through the indirect path
  task automatic page(input logic [7:0] sel, input logic [15:0] exp);
    wr(LPNP_ADDR_SEL, sel);
    wr(LPNP_ADDR_OFS, LPNP_OFS_HI);
    rd(LPNP_ADDR_DATA, exp[15:8]);
    wr(LPNP_ADDR_OFS, LPNP_OFS_LO);
    rd(LPNP_ADDR_DATA, exp[7:0]);
  endtask : page

  task automatic t_reset();
    page(8'h21, 16'h0000);
    check("ack_ready", {7'h00, np_ack_ready}, 8'h00);
  endtask : t_reset
  task automatic t_first_page();
    P.send(16'h0801, 1'b0, 3);
    #1 check("taken", n_taken, 8'h00);
    P.send(16'hE5A5, 1'b1, 3);
    #1 check("ack_ready", {7'h00, np_ack_ready}, 8'h01);
    check("taken", n_taken, 8'h01);
    page(8'h21, 16'hE5A5);
  endtask : t_first_page
  task automatic t_partial();
    P.send(16'h1A34, 1'b1, 2);
    P.send(16'h1A35, 1'b1, 2);
    page(8'h21, 16'hE5A5);
    P.send(16'h1A34, 1'b1, 3);
    page(8'h21, 16'h1A34);
    check("taken", n_taken, 8'h02);
    check("toggle_err", {7'h00, err_seen}, 8'h00);
  endtask : t_partial
  task automatic t_bad_toggle();
    P.send(16'h4855, 1'b1, 3);
    #1 check("toggle_err", {7'h00, err_seen}, 8'h01);
    check("taken", n_taken, 8'h02);
    page(8'h21, 16'h1A34);
  endtask : t_bad_toggle
  task automatic t_bad_select();
    page(8'h22, 16'h0000);
    page(8'h41, 16'h0000);
    rd(LPNP_ADDR_SEL, 8'h41);
    rd(LPNP_ADDR_OFS, LPNP_OFS_LO);
    wr(LPNP_ADDR_SEL, 8'h21);
    wr(LPNP_ADDR_OFS, 8'h12);
    rd(LPNP_ADDR_DATA, 8'h00);
    rd(8'h55, 8'h00);
    wr(LPNP_ADDR_DATA, 8'hFF);
    page(8'h21, 16'h1A34);
  endtask : t_bad_select

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    arst_n    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_first_page();
    t_partial();
    t_bad_toggle();
    t_bad_select();
    wrap_up();
  end
endmodule : tb
